// ### hw/rsi_top.sv
// reset-state initialiser: reset flags and reset values of core registers
// assumes reset sources are single-cycle pulses synchronous to clk_i
// and that rst_i is the power-on reset of the whole device

// ************************************************************
// reset-state initialiser
// ************************************************************
// Behaviour
// - power-on reset clears both time-out and power-down flags
// - low-voltage reset leaves both flags unchanged
// - normal-mode watchdog reset sets time-out flag, keeps power-down flag
// - halted watchdog reset sets both flags
// - power-on reset disables interrupts, program counter restarts at zero
// - power-on reset clears watchdog counter, which restarts counting
// - power-on reset leaves the timer stopped
// - power-on reset makes all port pins inputs
// - power-on reset points stack pointer to top of stack
// - every reset loads program counter low byte with zero
// - full resets: port data/direction ones, pull/wake zero; halted watchdog keeps
// - watchdog control resets to 0x53 except on halted watchdog reset
// - low-voltage select resets to 0x55 except on halted watchdog reset
// - system mode resets to 000-0011 except on halted watchdog reset
// - pointers, accumulator, table regs undefined on power/low-volt, kept on watchdog
// - timer and touch-key registers clear except on halted watchdog reset
// - halted watchdog reset touches only program counter, stack pointer, both flags and its interrupt status bit
module rsi_top import rsi_pkg::*; #(
	parameter logic [7:0] UNK_FILL = 8'h00
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic lvr_i,
	input wire logic wdt_timeout_i,
	input wire logic halted_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic timeout_flag_o,
	output logic powerdown_flag_o,
	output logic [7:0] prog_counter_low_o,
	output logic pc_clear_o,
	output logic stack_top_o,
	output logic int_disable_o,
	output logic wdt_clear_o,
	output logic timer_stop_o,
	output logic [7:0] system_mode_reg_o,
	output logic [7:0] watchdog_control_reg_o,
	output logic [7:0] lowvolt_select_reg_o,
	output logic [7:0] port_data_reg_o,
	output logic [7:0] port_direction_reg_o,
	output logic [7:0] port_pullhigh_reg_o,
	output logic [7:0] port_wake_reg_o
);
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic rsi_cls_t cls_of(input logic [4:0] idx);
		if (idx == IDX_PCL) begin
			return RSI_CLS_PC;
		end
		if (idx >= IDX_MP0 && idx <= IDX_TABLE_POINTER_HIGH) begin
			return RSI_CLS_UNK;
		end
		return RSI_CLS_CTL;
	endfunction : cls_of

	function automatic logic [7:0] rst_val(input logic [4:0] idx);
		unique case (idx)
			IDX_SYSTEM_MODE_REG: return RST_SYSTEM_MODE_REG;
			IDX_WATCHDOG_CONTROL_REG: return RST_WATCHDOG_CONTROL_REG;
			IDX_LOWVOLT_SELECT_REG: return RST_LOWVOLT_SELECT_REG;
			IDX_PDAT, IDX_PDIR: return RST_ONES;
			IDX_PPUL, IDX_PWAK: return RST_ZERO;
			IDX_MP0, IDX_MP1, IDX_ACC, IDX_TABLE_POINTER_LOW, IDX_TABLE_DATA_HIGH, IDX_TABLE_POINTER_HIGH: return UNK_FILL;
			default: return RST_ZERO;
		endcase
	endfunction : rst_val

	function automatic logic [7:0] msk_of(input logic [4:0] idx);
		return (idx == IDX_SYSTEM_MODE_REG) ? MSK_SYSTEM_MODE_REG : MSK_FULL;
	endfunction : msk_of

	// ************************************************************
	// reset classification
	// ************************************************************
	logic wdt_norm;
	logic wdt_halt;
	logic full_rst;
	logic any_rst;
	assign wdt_norm = wdt_timeout_i && !lvr_i && !halted_i;
	assign wdt_halt = wdt_timeout_i && !lvr_i && halted_i;
	assign full_rst = lvr_i || wdt_norm;
	assign any_rst = full_rst || wdt_halt;

	// ************************************************************
	// wishbone slave
	// ************************************************************
	logic [7:0] regs_q [NREG];
	logic [NEV-1:0] isr_q;
	logic [NEV-1:0] imr_q;
	logic to_q;
	logic pd_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [4:0] widx;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] rd_d;
	assign widx = wb_adr_i[ADR_LSB+4:ADR_LSB];
	assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];

	always_comb begin
		rd_d = RST_ZERO;
		if (widx < IDX_STAT) begin
			rd_d = regs_q[widx];
		end else if (widx == IDX_STAT) begin
			rd_d = {6'h00, pd_q, to_q};
		end else if (widx == IDX_ISR) begin
			rd_d = {5'h00, isr_q};
		end else if (widx == IDX_IMR) begin
			rd_d = {5'h00, imr_q};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
			if (wb_cyc_i && wb_stb_i && !ack_q) begin
				dat_q <= {24'h00_0000, rd_d};
			end
		end
	end

	// ************************************************************
	// reset flags
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			to_q <= 1'b0;
			pd_q <= 1'b0;
		end else if (lvr_i) begin
			to_q <= to_q;
			pd_q <= pd_q;
		end else if (wdt_norm) begin
			to_q <= 1'b1;
		end else if (wdt_halt) begin
			to_q <= 1'b1;
			pd_q <= 1'b1;
		end
	end

	// ************************************************************
	// register file with reset value sets
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NREG; i++) begin
				regs_q[i] <= rst_val(5'(i)) & msk_of(5'(i));
			end
		end else begin
			for (int i = 0; i < NREG; i++) begin
				if (cls_of(5'(i)) == RSI_CLS_PC && any_rst) begin
					regs_q[i] <= RST_ZERO;
				end else if (cls_of(5'(i)) == RSI_CLS_CTL && full_rst) begin
					regs_q[i] <= rst_val(5'(i)) & msk_of(5'(i));
				end else if (cls_of(5'(i)) == RSI_CLS_UNK && lvr_i) begin
					regs_q[i] <= UNK_FILL;
				end else if (!any_rst && wr_en && widx == 5'(i)) begin
					regs_q[i] <= wbyte & msk_of(5'(i));
				end
			end
		end
	end

	// ************************************************************
	// core reset strobes
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_clear_o <= 1'b1;
			stack_top_o <= 1'b1;
			int_disable_o <= 1'b1;
			wdt_clear_o <= 1'b1;
			timer_stop_o <= 1'b1;
		end else begin
			pc_clear_o <= any_rst;
			stack_top_o <= any_rst;
			int_disable_o <= full_rst;
			wdt_clear_o <= full_rst;
			timer_stop_o <= full_rst;
		end
	end

	// ************************************************************
	// interrupts
	// ************************************************************
	logic [NEV-1:0] ev;
	logic [NEV-1:0] clr;
	assign ev = {wdt_halt, wdt_norm, lvr_i};
	assign clr = (wr_en && widx == IDX_ISR) ? wbyte[NEV-1:0] : 3'h0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			isr_q <= 3'h0;
		end else begin
			isr_q <= (isr_q & ~clr) | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imr_q <= 3'h0;
		end else if (wr_en && widx == IDX_IMR) begin
			imr_q <= wbyte[NEV-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(isr_q & imr_q);
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign timeout_flag_o = to_q;
	assign powerdown_flag_o = pd_q;
	assign prog_counter_low_o = regs_q[IDX_PCL];
	assign system_mode_reg_o = regs_q[IDX_SYSTEM_MODE_REG];
	assign watchdog_control_reg_o = regs_q[IDX_WATCHDOG_CONTROL_REG];
	assign lowvolt_select_reg_o = regs_q[IDX_LOWVOLT_SELECT_REG];
	assign port_data_reg_o = regs_q[IDX_PDAT];
	assign port_direction_reg_o = regs_q[IDX_PDIR];
	assign port_pullhigh_reg_o = regs_q[IDX_PPUL];
	assign port_wake_reg_o = regs_q[IDX_PWAK];

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_POR_FLAGS: assert property ($past(rst_i) |-> !to_q && !pd_q)
		else $error("flags not cleared by power-on reset");
	AST_LVR_FLAGS: assert property ($past(lvr_i) |-> to_q == $past(to_q) && pd_q == $past(pd_q))
		else $error("low-voltage reset changed a flag");
	AST_WDN_FLAGS: assert property (wdt_norm |=> to_q && pd_q == $past(pd_q))
		else $error("normal watchdog reset flags wrong");
	AST_WDH_FLAGS: assert property (wdt_halt |=> to_q && pd_q)
		else $error("halted watchdog reset flags wrong");
	AST_PCL_ZERO: assert property (any_rst |=> prog_counter_low_o == RST_ZERO && pc_clear_o && stack_top_o)
		else $error("program counter not cleared");
	AST_PORT_VAL: assert property (full_rst |=>
		port_data_reg_o == RST_ONES && port_direction_reg_o == RST_ONES
		&& port_pullhigh_reg_o == RST_ZERO && port_wake_reg_o == RST_ZERO)
		else $error("port reset values wrong");
	AST_CTL_VAL: assert property (full_rst |=>
		watchdog_control_reg_o == RST_WATCHDOG_CONTROL_REG && lowvolt_select_reg_o == RST_LOWVOLT_SELECT_REG
		&& system_mode_reg_o == RST_SYSTEM_MODE_REG && regs_q[IDX_TMR] == RST_ZERO)
		else $error("control reset values wrong");
	AST_HALT_KEEP: assert property (wdt_halt |=>
		$stable(port_data_reg_o) && $stable(watchdog_control_reg_o)
		&& $stable(system_mode_reg_o) && $stable(regs_q[IDX_TKDAT]))
		else $error("halted watchdog reset changed state");
	AST_UNK_KEEP: assert property (wdt_timeout_i && !lvr_i |=>
		$stable(regs_q[IDX_MP0])
		&& $stable(regs_q[IDX_ACC]))
		else $error("watchdog reset changed pointer");
	AST_FULL_STROBE: assert property (full_rst |=>
		int_disable_o && wdt_clear_o && timer_stop_o ##1
		!int_disable_o || $past(full_rst))
		else $error("full reset strobes wrong");
	AST_IRQ_LEVEL: assert property (ev[EV_LVR] && imr_q[EV_LVR] && !(wr_en && widx == IDX_IMR) |-> ##2 irq_o)
		else $error("interrupt not raised");

	// ************************************************************
	// bus assertions
	// ************************************************************
	AST_WB_ONE: assert property (
		wb_ack_o
		|=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_WB_ANSWER: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o)
		else $error("request not answered");
	AST_WB_RDZERO: assert property (
		wb_ack_o
		|-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	// ************************************************************
	// reset value assertions
	// ************************************************************
	AST_POR_STROBE: assert property (
		$past(rst_i)
		|-> pc_clear_o && int_disable_o
		&& wdt_clear_o && timer_stop_o)
		else $error("power-on strobes missing");
	AST_POR_REGS: assert property (
		$past(rst_i)
		|-> port_direction_reg_o == RST_ONES && port_data_reg_o == RST_ONES
		&& port_pullhigh_reg_o == RST_ZERO)
		else $error("power-on port values wrong");
	AST_POR_STACK: assert property (
		$past(rst_i)
		|-> stack_top_o && prog_counter_low_o == RST_ZERO)
		else $error("power-on stack strobe missing");
	AST_LVR_UNK: assert property (
		lvr_i
		|=> regs_q[IDX_MP1] == UNK_FILL && regs_q[IDX_TABLE_DATA_HIGH] == UNK_FILL)
		else $error("low-voltage reset pointer fill wrong");
	AST_TMR_CLR: assert property (
		full_rst
		|=> regs_q[IDX_TMR] == RST_ZERO && regs_q[IDX_TKCNT] == RST_ZERO
		&& regs_q[IDX_TKDAT] == RST_ZERO)
		else $error("timer or touch registers not cleared");
	AST_LOWVOLT_SELECT_REG_VAL: assert property (
		full_rst
		|=> lowvolt_select_reg_o == RST_LOWVOLT_SELECT_REG)
		else $error("low-voltage select reset value wrong");
	AST_SYSTEM_MODE_REG_VAL: assert property (
		full_rst
		|=> system_mode_reg_o == (RST_SYSTEM_MODE_REG & MSK_SYSTEM_MODE_REG))
		else $error("system mode reset value wrong");

	// ************************************************************
	// reset strobe and selection assertions
	// ************************************************************
	AST_HALT_STROBE: assert property (
		wdt_halt
		|=> !int_disable_o && !wdt_clear_o && !timer_stop_o)
		else $error("halted watchdog reset gave full strobes");
	AST_HALT_SEL: assert property (
		wdt_timeout_i && !lvr_i && halted_i
		|=> powerdown_flag_o && timeout_flag_o)
		else $error("halted state not selected");
	AST_NORM_SEL: assert property (
		wdt_timeout_i && !lvr_i && !halted_i
		|=> int_disable_o && stack_top_o)
		else $error("running state not selected");
	AST_LVR_WINS: assert property (
		lvr_i && wdt_timeout_i
		|=> timeout_flag_o == $past(timeout_flag_o))
		else $error("watchdog won over low-voltage reset");
	AST_WDT_RESTART: assert property (
		full_rst
		|=> wdt_clear_o)
		else $error("watchdog clear strobe missing");
	AST_TIMER_STOP: assert property (
		full_rst
		|=> timer_stop_o)
		else $error("timer stop strobe missing");

	// ************************************************************
	// interrupt assertions
	// ************************************************************
	AST_ISR_SET: assert property (
		ev[EV_WDN]
		|=> isr_q[EV_WDN])
		else $error("event bit lost against clear");
	AST_IRQ_DROP: assert property (
		imr_q == 3'h0
		|=> !irq_o)
		else $error("interrupt raised while all masked");

	COV_LVR: cover property (lvr_i ##1 wb_ack_o);
	COV_WDN: cover property (wdt_norm);
	COV_WDH: cover property (wdt_halt ##1 stack_top_o);
	COV_IRQ: cover property (!irq_o ##1 irq_o);
endmodule : rsi_top

// ### hw/rsi_pkg.sv
// constants of the reset-state initialiser
// assumes a 32-bit classic wishbone slave port with byte addresses
package rsi_pkg;
	// ************************************************************
	// register indices (byte address = index * 4)
	// ************************************************************
	localparam int unsigned NREG = 17;
	localparam logic [4:0] IDX_SYSTEM_MODE_REG = 5'h00;
	localparam logic [4:0] IDX_WATCHDOG_CONTROL_REG = 5'h01;
	localparam logic [4:0] IDX_LOWVOLT_SELECT_REG = 5'h02;
	localparam logic [4:0] IDX_PDAT = 5'h03;
	localparam logic [4:0] IDX_PDIR = 5'h04;
	localparam logic [4:0] IDX_PPUL = 5'h05;
	localparam logic [4:0] IDX_PWAK = 5'h06;
	localparam logic [4:0] IDX_TMR = 5'h07;
	localparam logic [4:0] IDX_TKCNT = 5'h08;
	localparam logic [4:0] IDX_TKDAT = 5'h09;
	localparam logic [4:0] IDX_MP0 = 5'h0a;
	localparam logic [4:0] IDX_MP1 = 5'h0b;
	localparam logic [4:0] IDX_ACC = 5'h0c;
	localparam logic [4:0] IDX_TABLE_POINTER_LOW = 5'h0d;
	localparam logic [4:0] IDX_TABLE_DATA_HIGH = 5'h0e;
	localparam logic [4:0] IDX_TABLE_POINTER_HIGH = 5'h0f;
	localparam logic [4:0] IDX_PCL = 5'h10;
	localparam logic [4:0] IDX_STAT = 5'h11;
	localparam logic [4:0] IDX_ISR = 5'h12;
	localparam logic [4:0] IDX_IMR = 5'h13;
	localparam int unsigned ADR_LSB = 2;
	// ************************************************************
	// reset values and field layouts
	// ************************************************************
	localparam logic [7:0] RST_SYSTEM_MODE_REG = 8'h03;
	localparam logic [7:0] MSK_SYSTEM_MODE_REG = 8'hef;
	localparam logic [7:0] RST_WATCHDOG_CONTROL_REG = 8'h53;
	localparam logic [7:0] RST_LOWVOLT_SELECT_REG = 8'h55;
	localparam logic [7:0] RST_ONES = 8'hff;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] MSK_FULL = 8'hff;
	localparam int unsigned ST_TO = 0;
	localparam int unsigned ST_PD = 1;
	localparam int unsigned EV_LVR = 0;
	localparam int unsigned EV_WDN = 1;
	localparam int unsigned EV_WDH = 2;
	localparam int unsigned NEV = 3;
	// which reset groups touch a register
	typedef enum {RSI_CLS_CTL, RSI_CLS_UNK, RSI_CLS_PC} rsi_cls_t;
endpackage : rsi_pkg

// ### verification/reset_state_initialiser_tb.sv
// self-checking bench of the reset-state initialiser: random register contents, reset events, irq
// assumes rsi_top answers wishbone with one ack pulse and takes reset events as one-cycle pulses
module reset_state_initialiser_tb import rsi_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] UNK = 8'ha5;
	localparam int LIMIT = 6000;
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("[FAIL] %s expected %h seen %h", nm, (e), (g)); end end
	logic clk_i = 1'b0, rst_i = 1'b1, lvr_i = 1'b0, wdt_timeout_i = 1'b0, halted_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic wb_ack_o, irq_o, timeout_flag_o, powerdown_flag_o, pc_clear_o, stack_top_o;
	logic int_disable_o, wdt_clear_o, timer_stop_o;
	logic [7:0] prog_counter_low_o, system_mode_reg_o, watchdog_control_reg_o, lowvolt_select_reg_o;
	logic [7:0] port_data_reg_o, port_direction_reg_o, port_pullhigh_reg_o, port_wake_reg_o;
	logic [7:0] m [0:19];
	int n_fail = 0, n_compared = 0, cyc_n = 0;

	always #5 clk_i = ~clk_i;

	rsi_top #(.UNK_FILL(UNK)) u_dut (.*);

	// ************************************************************
	// bus, model and checks
	// ************************************************************
	task automatic close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	task automatic wb(input logic we, input logic [4:0] idx, input logic [7:0] d, input logic [3:0] sel);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {1'b0, idx, 2'b00};
		wb_sel_i <= sel;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
		if (we && sel[0] && idx != IDX_STAT && idx <= IDX_IMR)
			m[idx] = (idx == IDX_ISR) ? (m[idx] & ~d) : (idx == IDX_SYSTEM_MODE_REG) ? (d & MSK_SYSTEM_MODE_REG) : d;
	endtask : wb

	task automatic fill(input logic unk);
		m[IDX_SYSTEM_MODE_REG] = RST_SYSTEM_MODE_REG;
		m[IDX_WATCHDOG_CONTROL_REG] = RST_WATCHDOG_CONTROL_REG;
		m[IDX_LOWVOLT_SELECT_REG] = RST_LOWVOLT_SELECT_REG;
		m[IDX_PDAT] = RST_ONES;
		m[IDX_PDIR] = RST_ONES;
		for (int i = 5; i < 10; i++)
			m[i] = RST_ZERO;
		if (unk)
			for (int i = 10; i < 16; i++)
				m[i] = UNK;
		m[IDX_PCL] = RST_ZERO;
	endtask : fill

	task automatic chk_all();
		for (int i = 0; i < 21; i++) begin
			wb(1'b0, 5'(i), 8'h00, 4'hf);
			`CHK("register read", ((i < 20) ? {24'h0, m[i]} : 32'h0), rd)
		end
		`CHK("timeout flag", m[IDX_STAT][ST_TO], timeout_flag_o)
		`CHK("powerdown flag", m[IDX_STAT][ST_PD], powerdown_flag_o)
		`CHK("pcl", m[IDX_PCL], prog_counter_low_o)
		`CHK("system_mode_reg", m[IDX_SYSTEM_MODE_REG], system_mode_reg_o)
		`CHK("watchdog_control_reg", m[IDX_WATCHDOG_CONTROL_REG], watchdog_control_reg_o)
		`CHK("lowvolt_select_reg", m[IDX_LOWVOLT_SELECT_REG], lowvolt_select_reg_o)
		`CHK("port", {m[3], m[4], m[5], m[6]}, {port_data_reg_o, port_direction_reg_o, port_pullhigh_reg_o, port_wake_reg_o})
	endtask : chk_all

	task automatic ev(input int k);
		lvr_i <= (k == EV_LVR);
		wdt_timeout_i <= (k != EV_LVR);
		halted_i <= (k == EV_WDH);
		@(posedge clk_i);
		lvr_i <= 1'b0;
		wdt_timeout_i <= 1'b0;
		halted_i <= 1'($urandom);
		if (k != EV_WDH)
			fill(k == EV_LVR);
		m[IDX_PCL] = RST_ZERO;
		if (k == EV_WDN)
			m[IDX_STAT][ST_TO] = 1'b1;
		if (k == EV_WDH)
			m[IDX_STAT] = 8'h03;
		m[IDX_ISR][k] = 1'b1;
		#1;
		`CHK("pc strobes", 1'b1, pc_clear_o & stack_top_o)
		`CHK("full strobes", {3{k != EV_WDH}}, {int_disable_o, wdt_clear_o, timer_stop_o})
		@(posedge clk_i);
		#1;
		`CHK("irq", |(m[IDX_ISR] & m[IDX_IMR]), irq_o)
		@(posedge clk_i);
	endtask : ev

	// ************************************************************
	// main sequence and timeout
	// ************************************************************
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == LIMIT) begin
			n_fail++;
			close_out();
		end
	end

	initial begin
		void'($urandom(32'h37cbcab6));
		for (int i = 0; i < 20; i++)
			m[i] = 8'h00;
		fill(1'b1);
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk_all();
		wb(1'b1, IDX_IMR, 8'h07, 4'h1);
		for (int r = 0; r < 7; r++) begin
			for (int i = 0; i < 17; i++)
				wb(1'b1, 5'(i), 8'($urandom), 4'h1);
			wb(1'b1, IDX_STAT, 8'hff, 4'h1);
			wb(1'b1, IDX_WATCHDOG_CONTROL_REG, 8'h00, 4'he);
			ev(r % NEV);
			chk_all();
			wb(1'b1, IDX_ISR, 8'($urandom), 4'h1);
			wb(1'b1, IDX_IMR, 8'($urandom_range(0, 7)), 4'h1);
		end
		// power-on reset in mid-run with both flags set
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		`CHK("reset strobes", 5'h1f, {pc_clear_o, stack_top_o, int_disable_o, wdt_clear_o, timer_stop_o})
		fill(1'b1);
		for (int i = 17; i < 20; i++)
			m[i] = 8'h00;
		@(posedge clk_i);
		chk_all();
		close_out();
	end
endmodule : reset_state_initialiser_tb
